// *** pkg/sfc_pkg.sv ***
package sfc_pkg;
    // Command codes
    localparam logic [7:0] OP_WR_ENABLE = 8'h06;
    localparam logic [7:0] OP_WR_DISABLE = 8'h04;
    localparam logic [7:0] OP_SEC_PROG = 8'h42;
    localparam logic [7:0] OP_SEC_READ = 8'h48;
    localparam logic [7:0] OP_SET_PARAM = 8'hC0;
    localparam logic [7:0] OP_SET_WRAP = 8'h77;
    localparam logic [7:0] OP_WRAP_READ = 8'h0C;
    localparam logic [7:0] OP_QUAD_ON = 8'h38;
    localparam logic [7:0] OP_QUAD_OFF = 8'hFF;
    localparam logic [7:0] OP_RST_EN = 8'h66;
    localparam logic [7:0] OP_RST = 8'h99;
    // Timing, in ns and in cycles of CLK
    localparam int CLK_PERIOD_NS = 50;
    localparam int RST_TIME_NS = 30000;
    localparam int RST_CYC = (RST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PROG_TIME_NS = 200000;
    localparam int PROG_CYC = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Field positions and values after reset
    localparam int DUMMY_LSB = 4;
    localparam int WRAP_LSB = 0;
    localparam int SER_WRAP_LSB = 4;
    localparam logic [1:0] DUMMY_RST = 2'h0;
    localparam logic [1:0] WRAP_RST = 2'h0;
    localparam logic [3:0] SEC_DUMMY_CLKS = 4'h8;
    localparam logic [9:0] SEC_LAST = 10'h3FF;
    localparam logic [7:0] ERASED = 8'hFF;
    localparam logic [5:0] SYNC_RST = 6'h20;
    localparam int SEC_BYTES = 1024;

    typedef enum logic [2:0] {
        ST_OPC = 3'b000,
        ST_ADDR = 3'b001,
        ST_DUMMY = 3'b010,
        ST_WIN = 3'b011,
        ST_ROUT = 3'b100,
        ST_SKIP = 3'b101
    } sfc_state_e;

    typedef struct packed {
        logic write_enable_latch_bit;
        logic write_in_progress_bit;
        logic quad_mode;
        logic rst_busy;
        logic [1:0] dummy;
        logic [1:0] wrap;
    } sfc_status_s;
endpackage

// *** hdl/sfc_top.sv ***
`timescale 1ns/1ps
// Notes on behaviour
// - Sector program 42h taken only while the write enable latch is set.
// - Program writes 1 to 256 bytes, bits only go from one to zero.
// - With the lock bit set, sector program is ignored.
// - Sector read 48h: opcode, address, eight dummy clocks, then data.
// - Bits taken on rising clock, data driven on falling clock, MSB first.
// - Read address steps per byte and wraps from 3FFh to 00h.
// - Read parameter command C0h refused in serial mode.
// - Dummy field gives 2, 4, 6 or 8 dummy clocks in quad mode.
// - Wrap field gives 8, 16, 32 or 64 byte wrap length.
// - After reset wrap is 8 bytes and dummy count is 2.
// - In serial mode 77h bits 5:4 set wrap; kept into quad mode.
// - Wrap read 0Ch wraps inside the aligned wrap window.
// - One mode at a time; only 38h enters quad mode.
// - 38h ignored unless the quad enable bit is set.
// - The device starts in serial mode.
// - FFh in quad mode returns to serial mode.
// - Mode change keeps write enable latch and wrap setting.
// - Reset aborts work and clears latch, parameters and wrap bits.
// - Reset needs 66h then 99h, in either mode.
// - Any other command after 66h cancels the reset enable.
// - Reset takes about 30us and no command is taken meanwhile.
// - Write in progress reads 1 during a program cycle.
module sfc_top import sfc_pkg::*; #(
    parameter int PROG_CYC_P = PROG_CYC,
    parameter int RST_CYC_P = RST_CYC
) (
    input wire logic CLK,
    input wire logic RST,
    input wire logic CS_N,
    input wire logic SCK,
    input wire logic [3:0] IO_IN,
    output logic [3:0] IO_OUT,
    output logic [3:0] IO_OE,
    input wire logic QUAD_ENABLE,
    input wire logic SECURITY_LOCK,
    output logic [23:0] ARRAY_ADDR,
    input wire logic [7:0] ARRAY_DATA,
    output sfc_status_s STATUS
);
    logic [5:0] pin_raw, s1, s2, s3, lvl, lvl_d;
    sfc_state_e state;
    logic [7:0] in_sr, out_sr, opcode;
    logic [3:0] bit_cnt, out_cnt, dummy_left, io_out;
    logic [1:0] addr_cnt, dummy_f, wrap_f;
    logic [15:0] addr_sr;
    logic [23:0] rd_addr;
    logic [9:0] prog_addr;
    logic [12:0] prog_cnt;
    logic [12:0] rst_cnt;
    logic write_enable_latch_bit, quad, rst_en, got_data, qe_s, lock_s;
    logic [7:0] mem [SEC_BYTES];

    // Pins cross three stages; a level counts once stages two and three agree
    assign pin_raw = {CS_N, SCK, IO_IN};
    for (genvar i = 0; i < 6; i++)
    begin : g_sync
        always_ff @(posedge CLK)
        begin
            if (RST)
            begin
                s1[i] <= SYNC_RST[i];
                s2[i] <= SYNC_RST[i];
                s3[i] <= SYNC_RST[i];
                lvl[i] <= SYNC_RST[i];
                lvl_d[i] <= SYNC_RST[i];
            end
            else
            begin
                s1[i] <= pin_raw[i];
                s2[i] <= s1[i];
                s3[i] <= s2[i];
                if (s2[i] == s3[i])
                    lvl[i] <= s3[i];
                lvl_d[i] <= lvl[i];
            end
        end
    end

    // Edge and byte decode
    wire cs_idle = lvl[5];
    wire cs_end = lvl[5] & ~lvl_d[5];
    wire rise = ~cs_idle & lvl[4] & ~lvl_d[4];
    wire fall = ~cs_idle & ~lvl[4] & lvl_d[4];
    wire [3:0] w = quad ? 4'h4 : 4'h1;
    wire [7:0] nb = quad ? {in_sr[3:0], lvl[3:0]} : {in_sr[6:0], lvl[0]};
    wire byte_done = rise && (bit_cnt + w == 4'h8);
    wire opc_done = byte_done && state == ST_OPC;
    wire addr_last = byte_done && state == ST_ADDR && addr_cnt == 2'h2;
    wire busy_r = rst_cnt != 13'h0;
    wire busy_p = prog_cnt != 13'h0;
    wire is_rst = nb == OP_RST_EN || nb == OP_RST;
    wire take = !busy_r && (!busy_p || is_rst);
    wire do_rst = opc_done && take && nb == OP_RST && rst_en;
    wire go_prog = nb == OP_SEC_PROG && write_enable_latch_bit && !lock_s && !quad;
    wire go_addr = go_prog || (nb == OP_SEC_READ && !quad)
        || (nb == OP_SET_WRAP && !quad) || (nb == OP_WRAP_READ && quad);
    wire go_param = nb == OP_SET_PARAM && quad;
    wire quad_on = opc_done && take && nb == OP_QUAD_ON && !quad && qe_s;
    wire quad_off = opc_done && take && nb == OP_QUAD_OFF && quad;
    wire mem_we = byte_done && state == ST_WIN && opcode == OP_SEC_PROG;
    wire prog_go = cs_end && state == ST_WIN && opcode == OP_SEC_PROG && got_data;

    // Wrap window mask for 0Ch; security reads roll over the 10-bit sector
    wire [5:0] wmask = {wrap_f == 2'h3, wrap_f[1], wrap_f != 2'h0, 3'b111};
    wire [5:0] wrap_inc = (rd_addr[5:0] & ~wmask) | ((rd_addr[5:0] + 6'h1) & wmask);
    wire [23:0] next_rd = (opcode == OP_WRAP_READ)
        ? {rd_addr[23:6], wrap_inc}
        : {rd_addr[23:10], rd_addr[9:0] + 10'h1};
    wire [7:0] fetch = (opcode == OP_SEC_READ) ? mem[rd_addr[9:0]] : ARRAY_DATA;
    wire [3:0] next_dummy = (opcode == OP_SEC_READ)
        ? SEC_DUMMY_CLKS : {1'b0, dummy_f, 1'b0} + 4'h2;
    wire load_first = rise && state == ST_DUMMY && dummy_left == 4'h1;
    wire load_next = fall && state == ST_ROUT && (out_cnt + w == 4'h8);

    // Bit capture on rising link clock edges
    always_ff @(posedge CLK)
    begin
        if (RST || cs_idle)
        begin
            in_sr <= 8'h00;
            bit_cnt <= 4'h0;
        end
        else if (rise)
        begin
            in_sr <= nb;
            bit_cnt <= byte_done ? 4'h0 : bit_cnt + w;
        end
    end

    // Straps sampled on every clock, under reset as well
    always_ff @(posedge CLK)
    begin
        qe_s <= QUAD_ENABLE;
        lock_s <= SECURITY_LOCK;
    end

    // Frame sequencer; a frame always restarts at select
    always_ff @(posedge CLK)
    begin
        if (RST || cs_idle)
        begin
            state <= ST_OPC;
            addr_cnt <= 2'h0;
            got_data <= 1'b0;
            if (RST)
                opcode <= 8'h00;
        end
        else if (opc_done)
        begin
            opcode <= nb;
            state <= !take ? ST_SKIP : go_addr ? ST_ADDR : go_param ? ST_WIN : ST_SKIP;
        end
        else if (byte_done && state == ST_ADDR)
        begin
            addr_sr <= {addr_sr[7:0], nb};
            addr_cnt <= addr_cnt + 2'h1;
            if (addr_cnt == 2'h2)
                state <= (opcode == OP_SEC_READ || opcode == OP_WRAP_READ) ? ST_DUMMY : ST_WIN;
        end
        else if (load_first)
            state <= ST_ROUT;
        else if (byte_done && state == ST_WIN)
        begin
            got_data <= 1'b1;
            if (opcode != OP_SEC_PROG)
                state <= ST_SKIP;
        end
    end

    // Read side: dummy count, address, serialiser on falling edges
    always_ff @(posedge CLK)
    begin
        if (RST || cs_idle)
        begin
            io_out <= 4'h0;
            out_cnt <= 4'h0;
            dummy_left <= 4'h0;
        end
        else if (addr_last)
        begin
            rd_addr <= {addr_sr, nb};
            dummy_left <= next_dummy;
        end
        else if (rise && state == ST_DUMMY)
        begin
            dummy_left <= dummy_left - 4'h1;
            if (load_first)
            begin
                out_sr <= fetch;
                rd_addr <= next_rd;
            end
        end
        else if (fall && state == ST_ROUT)
        begin
            io_out <= quad ? out_sr[7:4] : {2'b00, out_sr[7], 1'b0};
            out_sr <= quad ? {out_sr[3:0], 4'h0} : {out_sr[6:0], 1'b0};
            out_cnt <= load_next ? 4'h0 : out_cnt + w;
            if (load_next)
            begin
                out_sr <= fetch;
                rd_addr <= next_rd;
            end
        end
    end

    // Program pointer stays in its 256-byte page
    always_ff @(posedge CLK)
    begin
        if (addr_last)
            prog_addr <= {addr_sr[1:0], nb};
        else if (mem_we)
            prog_addr <= {prog_addr[9:8], prog_addr[7:0] + 8'h01};
    end

    // Sector cells; programming can only clear bits
    for (genvar i = 0; i < SEC_BYTES; i++)
    begin : g_cell
        always_ff @(posedge CLK)
        begin
            if (RST)
                mem[i] <= ERASED;
            else if (mem_we && prog_addr == 10'(i))
                mem[i] <= mem[i] & nb;
        end
    end

    // Latch, mode, parameters and the two self-timed counters
    always_ff @(posedge CLK)
    begin
        if (RST || do_rst)
        begin
            write_enable_latch_bit <= 1'b0;
            quad <= 1'b0;
            rst_en <= 1'b0;
            dummy_f <= DUMMY_RST;
            wrap_f <= WRAP_RST;
            prog_cnt <= 13'h0;
            rst_cnt <= RST ? 13'h0 : 13'(RST_CYC_P);
        end
        else
        begin
            if (opc_done)
                rst_en <= take && nb == OP_RST_EN;
            if (opc_done && take && nb == OP_WR_ENABLE)
                write_enable_latch_bit <= 1'b1;
            else if (opc_done && take && nb == OP_WR_DISABLE)
                write_enable_latch_bit <= 1'b0;
            else if (prog_cnt == 13'h1)
                write_enable_latch_bit <= 1'b0;
            if (quad_on)
                quad <= 1'b1;
            else if (quad_off)
                quad <= 1'b0;
            if (byte_done && state == ST_WIN && opcode == OP_SET_PARAM)
            begin
                dummy_f <= nb[DUMMY_LSB+:2];
                wrap_f <= nb[WRAP_LSB+:2];
            end
            else if (byte_done && state == ST_WIN && opcode == OP_SET_WRAP)
                wrap_f <= nb[SER_WRAP_LSB+:2];
            if (prog_go)
                prog_cnt <= 13'(PROG_CYC_P);
            else if (busy_p)
                prog_cnt <= prog_cnt - 13'h1;
            if (busy_r)
                rst_cnt <= rst_cnt - 13'h1;
        end
    end

    // Outputs
    assign IO_OUT = io_out;
    assign IO_OE = (state == ST_ROUT && !cs_idle) ? (quad ? 4'hF : 4'h2) : 4'h0;
    assign ARRAY_ADDR = rd_addr;
    assign STATUS = '{write_enable_latch_bit: write_enable_latch_bit, write_in_progress_bit: busy_p, quad_mode: quad, rst_busy: busy_r,
        dummy: dummy_f, wrap: wrap_f};

    // Checks
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    sequence s_rst_taken;
        opc_done && nb == OP_RST && rst_en && take;
    endsequence

    a_prog_needs_wel: assert property (
        opc_done && nb == OP_SEC_PROG && !write_enable_latch_bit |=> state != ST_ADDR)
        else $error("program taken without write enable");
    a_lock_blocks: assert property (
        opc_done && nb == OP_SEC_PROG && lock_s |=> state == ST_SKIP)
        else $error("program taken while locked");
    a_param_serial: assert property (
        opc_done && nb == OP_SET_PARAM && !quad |=> state == ST_SKIP)
        else $error("read parameters taken in serial mode");
    a_quad_gate: assert property (
        opc_done && nb == OP_QUAD_ON && !qe_s && !quad |=> !quad)
        else $error("quad mode entered without enable bit");
    a_quad_exit: assert property (
        quad_off |=> !quad && $stable(write_enable_latch_bit) && $stable(wrap_f))
        else $error("quad exit wrong");
    a_reset_clear: assert property (
        s_rst_taken |=> !write_enable_latch_bit && dummy_f == 2'h0 && wrap_f == 2'h0 && !busy_p)
        else $error("reset left state behind");
    a_reset_hold: assert property (
        s_rst_taken |=> busy_r [*8] ##1 (rst_cnt == 13'(RST_CYC_P) - 13'd8))
        else $error("reset busy interval wrong");
    a_rst_cancel: assert property (
        opc_done && nb != OP_RST_EN |=> !rst_en)
        else $error("reset enable not cancelled");
    a_sec_roll: assert property (
        load_next && opcode == OP_SEC_READ && rd_addr[9:0] == SEC_LAST
        |=> rd_addr[9:0] == 10'h000)
        else $error("sector address did not roll over");
    a_wip_prog: assert property (
        prog_go |=> STATUS.write_in_progress_bit [*3])
        else $error("write in progress not shown");
endmodule

// *** tb/sfc_host.sv ***
`timescale 1ns/1ps
// Host model: mode 0 master, SCK low between frames
module sfc_host (
    input wire logic clk,
    output logic cs_n = 1'b1,
    output logic sck = 1'b0,
    output logic [3:0] io_in,
    input wire logic [3:0] io_out,
    input wire logic [3:0] io_oe
);
    logic [3:0] drv = 4'h0;
    logic qm = 1'b0;
    // Wire level from both drivers
    assign io_in = (io_oe & io_out) | (~io_oe & drv);
    // Four CLK per half period, 400 ns a link period; the sampler needs three
    task automatic tick();
        repeat (4) @(posedge clk);
        #1;
    endtask
    task automatic pulse(input logic [3:0] v);
        drv = v;
        tick();
        sck = 1'b1;
        tick();
        sck = 1'b0;
    endtask
    // MSB first; high nibble first in quad
    task automatic send(input logic [7:0] b);
        if (qm)
        begin
            pulse(b[7:4]);
            pulse(b[3:0]);
        end
        else
            for (int i = 7; i >= 0; i--)
                pulse({~drv[3:1], b[i]});
    endtask
    task automatic dummy(input int n);
        repeat (n) pulse(~drv);
    endtask
    // Released lines flip each unit so a stale value never matches
    // Taken late in the high phase: the answer trails the pin fall by five CLK
    task automatic get(output logic [7:0] b);
        b = 8'h00;
        repeat (qm ? 2 : 8)
        begin
            drv = ~drv;
            tick();
            sck = 1'b1;
            tick();
            b = qm ? {b[3:0], io_in} : {b[6:0], io_in[1]};
            sck = 1'b0;
        end
    endtask
    task automatic open_f();
        cs_n = 1'b0;
        tick();
    endtask
    // Select stays high eight CLK so a started program already shows busy
    task automatic close_f();
        tick();
        cs_n = 1'b1;
        tick();
        tick();
    endtask
    task automatic cmd(input logic [7:0] op);
        open_f();
        send(op);
        close_f();
    endtask
endmodule

// *** tb/tb.sv ***
`timescale 1ns/1ps
// Bench top: fixed-seed random data plus hand-picked corners
module tb import sfc_pkg::*;;
    logic CLK = 1'b0;
    logic RST = 1'b1;
    logic QUAD_ENABLE = 1'b0;
    logic SECURITY_LOCK = 1'b0;
    logic CS_N;
    logic SCK;
    logic [3:0] IO_IN;
    logic [3:0] IO_OUT;
    logic [3:0] IO_OE;
    logic [23:0] ARRAY_ADDR;
    logic [7:0] ARRAY_DATA;
    sfc_status_s STATUS;
    logic [7:0] sec [1024];
    int fails = 0;
    int checks = 0;
    integer seed = 32'hF0708E1A;
    logic [7:0] d0;
    logic [7:0] d1;
    logic [7:0] p;
    logic [1:0] w;
    logic [23:0] a;
    // 20 MHz system clock
    initial
    begin
        forever #25 CLK = ~CLK;
    end
    sfc_top #(.PROG_CYC_P(20)) i_sfc_top (.CLK(CLK), .RST(RST), .CS_N(CS_N), .SCK(SCK),
        .IO_IN(IO_IN), .IO_OUT(IO_OUT), .IO_OE(IO_OE), .QUAD_ENABLE(QUAD_ENABLE),
        .SECURITY_LOCK(SECURITY_LOCK), .ARRAY_ADDR(ARRAY_ADDR),
        .ARRAY_DATA(ARRAY_DATA), .STATUS(STATUS));
    sfc_host i_sfc_host (.clk(CLK), .cs_n(CS_N), .sck(SCK), .io_in(IO_IN),
        .io_out(IO_OUT), .io_oe(IO_OE));
    // Main array stand-in: each byte is a mix of its address
    function automatic logic [7:0] arr(input logic [23:0] x);
        return x[7:0] ^ 8'h5A;
    endfunction
    assign ARRAY_DATA = arr(ARRAY_ADDR);
    task automatic chk(input logic [7:0] g, input logic [7:0] e, input string m);
        checks++;
        if (g !== e)
        begin
            fails++;
            $display("[FAIL] %0t %s: %h not %h", $time, m, g, e);
        end
    endtask
    task automatic st(input logic [7:0] e, input string m);
        chk(STATUS, e, m);
        $display("done: %s", m);
    endtask
    task automatic results();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // Bounded wait for program or reset to finish
    task automatic wait_idle();
        int n;
        n = 0;
        while ((STATUS.write_in_progress_bit !== 1'b0 || STATUS.rst_busy !== 1'b0) && n < 2000)
        begin
            @(posedge CLK);
            #1;
            n++;
        end
        if (n == 2000)
        begin
            fails++;
            $display("[FAIL] %0t idle timeout", $time);
            results();
        end
    endtask
    task automatic addr(input logic [23:0] x);
        i_sfc_host.send(x[23:16]);
        i_sfc_host.send(x[15:8]);
        i_sfc_host.send(x[7:0]);
    endtask
    task automatic frame2(input logic [7:0] op, input logic [7:0] b);
        i_sfc_host.open_f();
        i_sfc_host.send(op);
        i_sfc_host.send(b);
        i_sfc_host.close_f();
    endtask
    // Shadow copy only follows a write that should be taken
    task automatic prog(input logic [9:0] ad, input logic [7:0] v, input logic ok);
        i_sfc_host.open_f();
        i_sfc_host.send(OP_SEC_PROG);
        addr({14'h0000, ad});
        i_sfc_host.send(v);
        i_sfc_host.close_f();
        chk(STATUS.write_in_progress_bit, ok, "busy");
        if (ok)
            sec[ad] = sec[ad] & v;
        wait_idle();
        if (ok)
            chk(STATUS.write_enable_latch_bit, 1'b0, "latch");
    endtask
    task automatic sread(input logic [9:0] ad, input int n);
        logic [7:0] b;
        i_sfc_host.open_f();
        i_sfc_host.send(OP_SEC_READ);
        addr({14'h0000, ad});
        i_sfc_host.dummy(8);
        for (int i = 0; i < n; i++)
        begin
            i_sfc_host.get(b);
            chk(b, sec[10'(ad + i)], "sector");
        end
        i_sfc_host.close_f();
    endtask
    // One full window plus one byte shows the wrap point
    task automatic wread(input logic [23:0] ad, input logic [1:0] dm, input logic [1:0] wr);
        logic [23:0] m;
        logic [7:0] b;
        m = 24'((8 << wr) - 1);
        i_sfc_host.open_f();
        i_sfc_host.send(OP_WRAP_READ);
        addr(ad);
        i_sfc_host.dummy(2 * (dm + 1));
        for (int i = 0; i <= m + 1; i++)
        begin
            i_sfc_host.get(b);
            chk(b, arr((ad & ~m) | ((ad + 24'(i)) & m)), "wrap");
        end
        i_sfc_host.close_f();
    endtask
    // Main sequence
    initial
    begin
        for (int i = 0; i < 1024; i++)
            sec[i] = ERASED;
        d0 = 8'($random(seed));
        d1 = 8'($random(seed));
        p = 8'($random(seed));
        w = 2'($random(seed));
        a = 24'($random(seed));
        repeat (5) @(posedge CLK);
        #1;
        RST = 1'b0;
        repeat (4) @(posedge CLK);
        #1;
        st(8'h00, "reset");
        prog(10'h3FF, d0, 1'b0);
        i_sfc_host.cmd(OP_WR_ENABLE);
        SECURITY_LOCK = 1'b1;
        prog(10'h3FF, d0, 1'b0);
        SECURITY_LOCK = 1'b0;
        prog(10'h3FF, d0, 1'b1);
        i_sfc_host.cmd(OP_WR_ENABLE);
        prog(10'h000, d1, 1'b1);
        sread(10'h3FE, 4);
        frame2(OP_SET_PARAM, 8'h33);
        st(8'h00, "param refused");
        i_sfc_host.open_f();
        i_sfc_host.send(OP_SET_WRAP);
        addr(a);
        i_sfc_host.send({2'h0, w, 4'h0});
        i_sfc_host.close_f();
        st({6'h00, w}, "serial wrap");
        // Latch set then dropped again; the next check sees it low
        i_sfc_host.cmd(OP_WR_ENABLE);
        i_sfc_host.cmd(OP_WR_DISABLE);
        i_sfc_host.cmd(OP_QUAD_ON);
        st({6'h00, w}, "no quad");
        QUAD_ENABLE = 1'b1;
        i_sfc_host.cmd(OP_WR_ENABLE);
        i_sfc_host.cmd(OP_QUAD_ON);
        i_sfc_host.qm = 1'b1;
        st({4'hA, 2'h0, w}, "quad on");
        frame2(OP_SET_PARAM, p);
        st({4'hA, p[5:4], p[1:0]}, "param");
        wread(a, p[5:4], p[1:0]);
        i_sfc_host.cmd(OP_QUAD_OFF);
        i_sfc_host.qm = 1'b0;
        st({4'h8, p[5:4], p[1:0]}, "quad off");
        i_sfc_host.cmd(OP_QUAD_ON);
        i_sfc_host.qm = 1'b1;
        chk(STATUS.write_in_progress_bit, 1'b0, "idle");
        i_sfc_host.cmd(OP_RST_EN);
        i_sfc_host.cmd(OP_WR_ENABLE);
        i_sfc_host.cmd(OP_RST);
        st({4'hA, p[5:4], p[1:0]}, "reset cancel");
        i_sfc_host.cmd(OP_RST_EN);
        i_sfc_host.cmd(OP_RST);
        i_sfc_host.qm = 1'b0;
        st(8'h10, "soft reset");
        i_sfc_host.cmd(OP_WR_ENABLE);
        wait_idle();
        st(8'h00, "busy refuse");
        results();
    end
endmodule
